// ==== rtl/cwsr_defs.svh ====
// constants for the configuration and wake status register bank
`ifndef CWSR_DEFS_SVH
`define CWSR_DEFS_SVH
`define CWSR_ADDR_STATUS 6'h31
`define CWSR_ADDR_CONFIG 6'h3F
`define CWSR_CFG_RESET 24'h800000
`define CWSR_CFG_WMASK 24'hFFFFF7
`define CWSR_B_WAKE_FN 23
`define CWSR_B_LIN_PAT 22
`define CWSR_B_LIN_FAST 21
`define CWSR_B_TH_SCOPE 20
`define CWSR_B_EC_HV 19
`define CWSR_B_V2_ROLE 18
`define CWSR_B_SUP_UNLK 17
`define CWSR_B_WD_UNLK 16
`define CWSR_B_M_HS1 15
`define CWSR_B_M_LS1 14
`define CWSR_B_M_TW 13
`define CWSR_B_M_EC 12
`define CWSR_B_M_OL 11
`define CWSR_B_M_SPI 10
`define CWSR_B_M_PHY 9
`define CWSR_B_M_GW 8
`define CWSR_B_PUMP_UNLK 7
`define CWSR_B_PUMP_LOW 6
`define CWSR_B_DITH 5
`define CWSR_B_FS_FORCE 4
`define CWSR_B_BRIDGE_A 2
`define CWSR_B_BRIDGE_B 1
`define CWSR_B_WD_SVC 0
`define CWSR_STATE_POWERON 2'h2
`define CWSR_CLUSTERS 5
`endif

// ==== rtl/cwsr_pkg.sv ====
// types for the configuration and wake status register bank
package cwsr_pkg;
    typedef enum logic [1:0] {
        CWSR_OP_READ = 2'h0,
        CWSR_OP_WRITE = 2'h1,
        CWSR_OP_RDCLR = 2'h2,
        CWSR_OP_RSVD = 2'h3
    } cwsr_op_t;
    typedef struct packed {
        logic valid;
        cwsr_op_t op;
        logic [5:0] addr;
        logic [23:0] data;
    } cwsr_cmd_t;
    typedef struct packed {
        logic open_hs1;
        logic open_ls1;
        logic open_ec;
        logic open_other;
        logic thermal_warn;
        logic other_warn;
        logic spi_err;
        logic phy_err;
    } cwsr_fault_t;
    typedef struct packed {
        logic global_error;
        logic spi_error;
        logic phy_error;
        logic functional_error;
        logic global_warning;
    } cwsr_gsb_t;
endpackage : cwsr_pkg

// ==== rtl/cwsr_sticky.sv ====
// bank of set-dominant sticky flags cleared by read-and-clear
`timescale 1ns/1ps
`default_nettype none
module cwsr_sticky #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // events and clear
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clear,
    // flags
    output logic [WIDTH-1:0] o_flag
);
    // each flag keeps its own set-wins register
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_flag
            always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_flag[g] <= 1'b0;
                end else if (i_set[g]) begin
                    o_flag[g] <= 1'b1;
                end else if (i_clear) begin
                    o_flag[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : cwsr_sticky
`default_nettype wire

// ==== rtl/cwsr_regs.sv ====
// configuration and wake status registers behind the serial command port
`timescale 1ns/1ps
`default_nettype none
`include "cwsr_defs.svh"
module cwsr_regs (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // decoded serial commands, one pulse per frame
    input wire cwsr_pkg::cwsr_cmd_t i_cmd,
    output logic [23:0] o_rdata,
    output logic o_invalid_cmd,
    // wake pin and wake source pulses
    input wire logic i_wake_input_pin,
    input wire logic i_wake_overvoltage,
    input wire logic i_wake_can,
    input wire logic i_wake_lin,
    input wire logic i_wake_timer,
    // watchdog and device events
    input wire logic i_watchdog_fail,
    input wire logic i_watchdog_valid_service,
    input wire logic i_forced_standby_wd,
    input wire logic i_forced_standby_heat,
    input wire logic [1:0] i_device_state,
    input wire logic [`CWSR_CLUSTERS-1:0] i_cluster_thermal_flags,
    // fault sources feeding the global status byte, and the pump low-voltage input
    input wire cwsr_pkg::cwsr_fault_t i_fault,
    input wire logic i_pump_voltage_low,
    // configuration outputs
    output logic o_wake_pin_function_select,
    output logic o_lin_wake_pattern_select,
    output logic o_lin_fast_rate_select,
    output logic o_thermal_cutoff_scope,
    output logic o_second_supply_role,
    output logic o_electrochrome_high_volt,
    output logic o_pump_dither_off,
    output logic o_bridge_a_motor_split,
    output logic o_bridge_b_motor_split,
    output logic o_watchdog_service_bit,
    // guarded settings write enables
    output logic o_load_supervision_write_ok,
    output logic o_watchdog_setup_write_ok,
    output logic o_pump_stop_write_ok,
    // fail-safe and pump
    output logic o_force_failsafe_outputs,
    output logic o_failsafe_no_reset,
    output logic o_pump_voltage_low_flag,
    output logic o_pump_outputs_off,
    // global status byte
    output cwsr_pkg::cwsr_gsb_t o_global_status_byte
);
    import cwsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    logic [23:0] cfg;
    logic [23:0] next_cfg;
    wire hit_cfg = i_cmd.addr == `CWSR_ADDR_CONFIG;
    wire hit_st = i_cmd.addr == `CWSR_ADDR_STATUS;
    wire is_wr = i_cmd.valid && i_cmd.op == CWSR_OP_WRITE;
    wire is_rc = i_cmd.valid && i_cmd.op == CWSR_OP_RDCLR;
    wire is_rd = is_rc || (i_cmd.valid && i_cmd.op == CWSR_OP_READ);
    wire bad_op = i_cmd.valid && i_cmd.op == CWSR_OP_RSVD;
    wire bad_addr = i_cmd.valid && !hit_cfg && !hit_st;
    wire st_write = is_wr && hit_st;
    wire cfg_write = is_wr && hit_cfg && !bad_op;
    wire st_clear = is_rc && hit_st && !bad_op;
    wire any_frame = i_cmd.valid && !st_write && !bad_op && !bad_addr;

    // unlock bits survive exactly one later frame
    wire unlk_sup = cfg[`CWSR_B_SUP_UNLK];
    wire unlk_wd = cfg[`CWSR_B_WD_UNLK];
    wire unlk_pump = cfg[`CWSR_B_PUMP_UNLK];
    logic armed_sup;
    logic armed_wd;
    logic armed_pump;

    ////////////////////////////////////////////////////////////////////////
    // configuration next value
    always_comb begin
        next_cfg = cfg;
        if (any_frame) begin
            // one-shot unlocks clear after the command that follows them
            if (armed_sup) next_cfg[`CWSR_B_SUP_UNLK] = 1'b0;
            if (armed_wd) next_cfg[`CWSR_B_WD_UNLK] = 1'b0;
            if (armed_pump) next_cfg[`CWSR_B_PUMP_UNLK] = 1'b0;
        end
        if (cfg_write) begin
            next_cfg = i_cmd.data & `CWSR_CFG_WMASK;
            if (armed_sup) next_cfg[`CWSR_B_SUP_UNLK] = 1'b0;
            if (armed_wd) next_cfg[`CWSR_B_WD_UNLK] = 1'b0;
            if (armed_pump) next_cfg[`CWSR_B_PUMP_UNLK] = 1'b0;
        end
    end

    // configuration register
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg <= `CWSR_CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // arm an unlock after the frame that set it, so the next frame uses it
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            armed_sup <= 1'b0;
            armed_wd <= 1'b0;
            armed_pump <= 1'b0;
        end else if (any_frame) begin
            armed_sup <= next_cfg[`CWSR_B_SUP_UNLK];
            armed_wd <= next_cfg[`CWSR_B_WD_UNLK];
            armed_pump <= next_cfg[`CWSR_B_PUMP_UNLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake pin synchroniser and live level
    logic pin_meta;
    logic pin_sync;
    logic wake_pin_level;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= i_wake_input_pin;
            pin_sync <= pin_meta;
        end
    end

    // level follows pin only while it serves as wake input
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_pin_level <= 1'b0;
        end else if (!cfg[`CWSR_B_WAKE_FN]) begin
            wake_pin_level <= pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched status bits: wake sources, forced standby, watchdog failure
    logic [7:0] sticky;
    logic pin_wake_ev;
    logic pin_prev;
    // set order follows the status word from bit 23 downwards
    wire [7:0] sticky_set = {i_wake_overvoltage, pin_wake_ev,
        i_wake_can, i_wake_lin, i_wake_timer, i_forced_standby_heat,
        i_forced_standby_wd, i_watchdog_fail};
    cwsr_sticky #(
        .WIDTH(8)
    ) u_sticky (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_set(sticky_set),
        .i_clear(st_clear),
        .o_flag(sticky)
    );
    // a pin wake is a rising level seen while the pin is a wake input
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_prev <= 1'b0;
            pin_wake_ev <= 1'b0;
        end else begin
            pin_prev <= pin_sync;
            pin_wake_ev <= pin_sync && !pin_prev && !cfg[`CWSR_B_WAKE_FN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog failure counter, device state
    logic [3:0] wd_count;
    logic [1:0] dev_state;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wd_count <= 4'h0;
        end else if (i_watchdog_valid_service) begin
            wd_count <= 4'h0;
        end else if (i_watchdog_fail && wd_count != 4'hF) begin
            wd_count <= wd_count + 4'h1;
        end
    end

    // device state is sampled only at a read-and-clear
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dev_state <= `CWSR_STATE_POWERON;
        end else if (st_clear) begin
            dev_state <= i_device_state;
        end
    end

    wire thermal_one = |i_cluster_thermal_flags;

    ////////////////////////////////////////////////////////////////////////
    // pump-low flag: latched or live
    logic pump_latch;
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pump_latch <= 1'b0;
        end else if (i_pump_voltage_low) begin
            pump_latch <= 1'b1;
        end else if (st_clear || cfg[`CWSR_B_PUMP_LOW]) begin
            pump_latch <= 1'b0;
        end
    end
    wire pump_flag = cfg[`CWSR_B_PUMP_LOW] ? i_pump_voltage_low :
        pump_latch;

    ////////////////////////////////////////////////////////////////////////
    // global status byte with masking
    wire open_any = i_fault.open_hs1 | i_fault.open_ls1 | i_fault.open_ec |
        i_fault.open_other;
    wire open_err = (i_fault.open_hs1 & !cfg[`CWSR_B_M_HS1]) |
        (i_fault.open_ls1 & !cfg[`CWSR_B_M_LS1]) |
        (i_fault.open_ec & !cfg[`CWSR_B_M_EC]);
    wire open_unmasked = open_err & !cfg[`CWSR_B_M_OL];
    wire tw_err = i_fault.thermal_warn & !cfg[`CWSR_B_M_TW];
    wire spi_err = i_fault.spi_err & !cfg[`CWSR_B_M_SPI];
    wire phy_err = i_fault.phy_err & !cfg[`CWSR_B_M_PHY];
    wire gw_err = i_fault.other_warn & !cfg[`CWSR_B_M_GW];
    wire other_open = i_fault.open_other & !cfg[`CWSR_B_M_OL];
    cwsr_gsb_t next_gsb;
    assign next_gsb.global_error = open_unmasked | other_open | tw_err |
        spi_err | phy_err | gw_err;
    assign next_gsb.spi_error = i_fault.spi_err;
    assign next_gsb.phy_error = i_fault.phy_err;
    assign next_gsb.functional_error = open_any;
    assign next_gsb.global_warning = i_fault.thermal_warn |
        i_fault.other_warn;

    ////////////////////////////////////////////////////////////////////////
    // status word assembly and read data
    wire [23:0] status_word = {sticky[7], wake_pin_level, 1'b0, sticky[6],
        sticky[5], sticky[4], sticky[3], 1'b0, 1'b0, 3'h0, wd_count,
        dev_state, 1'b0, thermal_one, sticky[2], sticky[1], sticky[0], 1'b0};
    wire [23:0] next_rdata = !is_rd ? o_rdata : hit_cfg ? cfg :
        hit_st ? status_word : 24'h000000;

    // registered outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 24'h000000;
            o_invalid_cmd <= 1'b0;
            o_global_status_byte <= '0;
            o_pump_voltage_low_flag <= 1'b0;
            o_pump_outputs_off <= 1'b0;
        end else begin
            o_rdata <= next_rdata;
            o_invalid_cmd <= st_write | bad_op | bad_addr;
            o_global_status_byte <= next_gsb;
            o_pump_voltage_low_flag <= pump_flag;
            o_pump_outputs_off <= pump_flag;
        end
    end

    // configuration fields out
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wake_pin_function_select <= 1'b1;
            o_lin_wake_pattern_select <= 1'b0;
            o_lin_fast_rate_select <= 1'b0;
            o_thermal_cutoff_scope <= 1'b0;
            o_second_supply_role <= 1'b0;
            o_electrochrome_high_volt <= 1'b0;
            o_pump_dither_off <= 1'b0;
            o_bridge_a_motor_split <= 1'b0;
            o_bridge_b_motor_split <= 1'b0;
            o_watchdog_service_bit <= 1'b0;
            o_force_failsafe_outputs <= 1'b0;
            o_failsafe_no_reset <= 1'b0;
        end else begin
            o_wake_pin_function_select <= next_cfg[`CWSR_B_WAKE_FN];
            o_lin_wake_pattern_select <= next_cfg[`CWSR_B_LIN_PAT];
            o_lin_fast_rate_select <= next_cfg[`CWSR_B_LIN_FAST];
            o_thermal_cutoff_scope <= next_cfg[`CWSR_B_TH_SCOPE];
            o_second_supply_role <= next_cfg[`CWSR_B_V2_ROLE];
            o_electrochrome_high_volt <= next_cfg[`CWSR_B_EC_HV];
            o_pump_dither_off <= next_cfg[`CWSR_B_DITH];
            o_bridge_a_motor_split <= next_cfg[`CWSR_B_BRIDGE_A];
            o_bridge_b_motor_split <= next_cfg[`CWSR_B_BRIDGE_B];
            o_watchdog_service_bit <= next_cfg[`CWSR_B_WD_SVC];
            o_force_failsafe_outputs <= next_cfg[`CWSR_B_FS_FORCE];
            o_failsafe_no_reset <= next_cfg[`CWSR_B_FS_FORCE];
        end
    end

    // write permission for guarded settings elsewhere
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_load_supervision_write_ok <= 1'b0;
            o_watchdog_setup_write_ok <= 1'b0;
            o_pump_stop_write_ok <= 1'b0;
        end else begin
            o_load_supervision_write_ok <= next_cfg[`CWSR_B_SUP_UNLK];
            o_watchdog_setup_write_ok <= next_cfg[`CWSR_B_WD_UNLK];
            o_pump_stop_write_ok <= next_cfg[`CWSR_B_PUMP_UNLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_CFG_RESET_WAKE: assert property (@(posedge i_clk_sys)
        $rose(i_rst_b) |-> cfg[`CWSR_B_WAKE_FN])
        else $error("wake pin function not 1 after reset");
    AST_UNLOCK_ONE_SHOT: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) armed_sup && any_frame |=> !unlk_sup)
        else $error("supervision unlock did not clear");
    AST_WD_UNLOCK: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) armed_wd && any_frame |=> !unlk_wd)
        else $error("watchdog unlock did not clear");
    AST_PUMP_UNLOCK: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) armed_pump && any_frame |=> !unlk_pump)
        else $error("pump unlock did not clear");
    AST_SPI_MASK: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) cfg[`CWSR_B_M_SPI] && i_fault == 8'h02 |=>
        o_global_status_byte.spi_error && !o_global_status_byte.global_error)
        else $error("masked serial error reached global error");
    AST_TW_MASK: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) cfg[`CWSR_B_M_TW] && i_fault == 8'h08 |=>
        o_global_status_byte.global_warning &&
        !o_global_status_byte.global_error)
        else $error("masked thermal warning reached global error");
    AST_STATUS_WRITE: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) st_write |=> o_invalid_cmd && $stable(cfg))
        else $error("status write not flagged");
    AST_WD_COUNT_CLR: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) i_watchdog_valid_service |=> wd_count == 4'h0)
        else $error("watchdog count not cleared by service");
    AST_THERMAL_OR: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) is_rd && hit_st |=> o_rdata[4] ==
        $past(|i_cluster_thermal_flags))
        else $error("thermal level one not OR of clusters");
    AST_WAKE_LATCH: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b) i_wake_can |=> sticky[5])
        else $error("can wake not latched");
    COV_CFG_WRITE: cover property (@(posedge i_clk_sys) cfg_write);
    COV_RDCLR: cover property (@(posedge i_clk_sys) st_clear);
    COV_UNLOCK: cover property (@(posedge i_clk_sys) armed_pump && cfg_write);
    COV_PIN_WAKE: cover property (@(posedge i_clk_sys) pin_wake_ev);
endmodule : cwsr_regs
`default_nettype wire

// ==== sim/cwsr_host.sv ====
// host model issuing decoded serial frames to the register bank
`timescale 1ns/1ps
`default_nettype none
module cwsr_host (
    // clock
    input wire logic i_clk_sys,
    // frame towards the bank
    output var cwsr_pkg::cwsr_cmd_t o_cmd
);
    import cwsr_pkg::*;
    initial o_cmd = '0;
    // one frame per call, held across one rising edge, then scrambled
    task automatic send(input cwsr_op_t op, input logic [5:0] addr,
                        input logic [23:0] data);
        @(negedge i_clk_sys);
        o_cmd <= '{1'b1, op, addr, data};
        @(negedge i_clk_sys);
        o_cmd <= '{1'b0, cwsr_op_t'(~op), ~addr, ~data};
    endtask : send
endmodule : cwsr_host
`default_nettype wire

// ==== sim/cwsr_regs_test.sv ====
// self-checking bench for the configuration and wake status registers
`timescale 1ns/1ps
`default_nettype none
`include "cwsr_defs.svh"
module cwsr_regs_test;
    import cwsr_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic pin = 1'b0;
    logic [4:0] ev = '0; // overvoltage, can, lin, timer, watchdog fail
    logic svc = 1'b0;
    logic [1:0] fsb = '0;
    logic [1:0] dstate = 2'h1;
    logic [4:0] clus = '0;
    logic plow = 1'b0;
    logic rd_pend = 1'b0;
    cwsr_fault_t flt = '0;
    cwsr_cmd_t cmd;
    cwsr_gsb_t global_status_byte;
    logic [23:0] rdata;
    logic [23:0] d;
    logic inv;
    logic [6:0] cfg_o;
    logic [2:0] unlk;
    logic [3:0] fsp;
    logic [2:0] misc_o;
    logic [23:0] exp_q[$];
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'h721be585;
    int mb[8] = '{9, 10, 8, 13, 11, 12, 14, 15};
    int ub[3] = '{7, 16, 17};
    ////////////////////////////////////////////////////////////////////////
    always #50 i_clk_sys = ~i_clk_sys;
    cwsr_host host_u (.i_clk_sys(i_clk_sys), .o_cmd(cmd));
    cwsr_regs dut_u (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cmd(cmd),
        .o_rdata(rdata), .o_invalid_cmd(inv),
        .i_wake_input_pin(pin), .i_wake_overvoltage(ev[4]),
        .i_wake_can(ev[3]), .i_wake_lin(ev[2]), .i_wake_timer(ev[1]),
        .i_watchdog_fail(ev[0]), .i_watchdog_valid_service(svc),
        .i_forced_standby_wd(fsb[0]), .i_forced_standby_heat(fsb[1]),
        .i_device_state(dstate), .i_cluster_thermal_flags(clus),
        .i_fault(flt), .i_pump_voltage_low(plow),
        .o_wake_pin_function_select(cfg_o[6]),
        .o_lin_wake_pattern_select(cfg_o[5]),
        .o_lin_fast_rate_select(cfg_o[4]),
        .o_thermal_cutoff_scope(cfg_o[3]), .o_second_supply_role(cfg_o[2]),
        .o_electrochrome_high_volt(misc_o[2]), .o_pump_dither_off(misc_o[1]),
        .o_bridge_a_motor_split(cfg_o[1]),
        .o_bridge_b_motor_split(cfg_o[0]),
        .o_watchdog_service_bit(misc_o[0]),
        .o_load_supervision_write_ok(unlk[2]),
        .o_watchdog_setup_write_ok(unlk[1]), .o_pump_stop_write_ok(unlk[0]),
        .o_force_failsafe_outputs(fsp[2]), .o_failsafe_no_reset(fsp[1]),
        .o_pump_voltage_low_flag(fsp[0]), .o_pump_outputs_off(fsp[3]),
        .o_global_status_byte(global_status_byte));
    // compare, count and report
    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        if (exp_q.size() != 0) begin
            miscompares++;
        end
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // read frame whose answer is noted for the monitor
    task automatic rd(input cwsr_op_t op, input logic [5:0] a,
                      input logic [23:0] e);
        exp_q.push_back(e);
        host_u.send(op, a, 24'h0);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : cyc
    task automatic wr(input logic [23:0] v);
        host_u.send(CWSR_OP_WRITE, `CWSR_ADDR_CONFIG, v);
    endtask : wr
    // monitor: a read answer lands one cycle after its frame
    always @(posedge i_clk_sys) begin
        rd_pend <= cmd.valid && (cmd.op == CWSR_OP_READ ||
                                 cmd.op == CWSR_OP_RDCLR);
    end
    always @(negedge i_clk_sys) begin
        if (rd_pend === 1'b1 && exp_q.size() > 0) begin
            check("rdata", rdata, exp_q.pop_front());
        end
    end
    // watchdog on a hang
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
    // main sequence
    initial begin
        cyc(4);
        i_rst_b = 1'b1;
        rd(CWSR_OP_READ, `CWSR_ADDR_CONFIG, `CWSR_CFG_RESET);
        check("cfg", {17'h0, cfg_o}, 24'h40);
        repeat (4) begin
            d = 24'($random(seed)) & 24'hFCFF77;
            wr(d);
            check("cfg", {17'h0, cfg_o},
                  {17'h0, d[23:20], d[18], d[2:1]});
            check("misc", {21'h0, misc_o},
                  {21'h0, d[19], d[5], d[0]});
            rd(CWSR_OP_READ, `CWSR_ADDR_CONFIG, d);
        end
        for (int i = 0; i < 3; i++) begin
            wr(24'h1 << ub[i]);
            check("unlock", {21'h0, unlk}, 24'h1 << i);
            wr(24'h1 << ub[i]);
            check("unlock", {21'h0, unlk}, 24'h0);
        end
        wr(24'h0);
        for (int i = 0; i < 3; i++) begin
            host_u.send(i == 1 ? CWSR_OP_RSVD : CWSR_OP_WRITE,
                        i == 2 ? 6'h3E : `CWSR_ADDR_STATUS, 24'hFFFFFF);
            check("invalid", {23'h0, inv}, 24'h1);
        end
        rd(CWSR_OP_READ, `CWSR_ADDR_CONFIG, 24'h0);
        pin = 1'b1;
        cyc(4);
        clus = 5'h04;
        ev = 5'h1F;
        fsb = 2'h3;
        cyc(1);
        ev = '0;
        fsb = '0;
        repeat (2) begin
            cyc(1);
            ev[0] = 1'b1;
            cyc(1);
            ev[0] = 1'b0;
        end
        rd(CWSR_OP_RDCLR,
           `CWSR_ADDR_STATUS, 24'hDE039E);
        rd(CWSR_OP_READ,
           `CWSR_ADDR_STATUS, 24'h400350);
        svc = 1'b1;
        cyc(1);
        svc = 1'b0;
        clus = '0;
        wr(`CWSR_CFG_RESET);
        pin = 1'b0;
        cyc(4);
        rd(CWSR_OP_READ,
           `CWSR_ADDR_STATUS, 24'h400040);
        for (int k = 0; k < 8; k++) begin
            for (int m = 0; m < 2; m++) begin
                wr(24'(m) << mb[k]);
                flt = cwsr_fault_t'(8'h1 << k);
                cyc(2);
                check("gsb",
                      {19'h0, global_status_byte},
                      {19'h0, m == 0, k == 1, k == 0,
                      k > 3, k == 2 || k == 3});
                flt = '0;
            end
        end
        wr(24'h10);
        plow = 1'b1;
        cyc(2);
        plow = 1'b0;
        cyc(2);
        check("fs pump", {20'h0, fsp}, 24'hF);
        wr(24'h40);
        plow = 1'b1;
        cyc(2);
        check("fs pump", {20'h0, fsp}, 24'h9);
        plow = 1'b0;
        cyc(2);
        check("fs pump", {20'h0, fsp}, 24'h0);
        cyc(2);
        close_out();
    end
endmodule : cwsr_regs_test
`default_nettype wire
